// ==== verilog/mmrd_pkg.sv ====
// Constants, types and helpers shared by the memory map remap decoder.
`default_nettype none
package mmrd_pkg;

  // System register page and the remap control byte
  localparam logic [31:0] MMR_PAGE_BASE  = 32'hFFFF0000;
  localparam logic [31:0] SYSCTL_BASE    = 32'hFFFF0200;
  localparam logic [31:0] REMAP_OFFSET   = 32'h00000220;
  localparam logic [31:0] REMAP_ADDR     = MMR_PAGE_BASE + REMAP_OFFSET;
  localparam int          REMAP_W        = 8;
  localparam logic [7:0]  REMAP_RST      = 8'h01;
  localparam int          REMAP_SEL_BIT  = 0;

  // Address zero mirror window
  localparam logic [31:0] MIRROR_BYTES   = 32'h00020000;

  // SRAM: 2k words of 32 bits
  localparam logic [31:0] SRAM_BASE      = 32'h00040000;
  localparam logic [31:0] SRAM_BYTES     = 32'h00002000;
  localparam int          SRAM_AW        = 11;
  localparam int          SRAM_WORDS     = 2048;
  localparam int          SRAM_IDX_LSB   = 2;

  // Nonvolatile array: block 1 at 0x80000, block 0 at 0x90000, 16 bits wide
  localparam logic [31:0] NV_BLK1_BASE   = 32'h00080000;
  localparam logic [31:0] NV_BLK0_BASE   = 32'h00090000;
  localparam logic [31:0] NV_BLK0_END    = 32'h0009F700;
  localparam logic [31:0] NV_SPAN        = 32'h00020000;
  localparam int          NV_AW          = 16;
  localparam int          NV_HW_DEPTH    = 65536;
  localparam int          NV_HW_LSB      = 1;
  localparam logic [15:0] NV_BOOT_HW     = 16'h0400;
  localparam logic [15:0] NV_BOOT_START  = 16'hFFFF - NV_BOOT_HW + 16'h0001;
  localparam int          PAGE_LSB       = 9;
  localparam int          NV_PAGE_W      = 8;

  // Access sizes on the core bus
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_HALF = 2'h1,
    SZ_WORD = 2'h2
  } mmrd_size_t;

  // Decoded target of an access
  typedef enum logic [1:0] {RG_NONE, RG_SRAM, RG_NV, RG_REMAP} mmrd_region_t;

  // Sequencer states
  typedef enum logic [2:0] {ST_IDLE, ST_MEM, ST_NV_HI, ST_NV_CAP, ST_DONE} mmrd_state_t;

  // Little-endian byte lanes touched by an access
  function automatic logic [3:0] byte_lanes(input mmrd_size_t sz, input logic [1:0] a);
    unique case (sz)
      SZ_BYTE: return 4'h1 << a;
      SZ_HALF: return a[1] ? 4'hC : 4'h3;
      SZ_WORD: return 4'hF;
      default: return 4'h0;
    endcase
  endfunction

endpackage
`default_nettype wire

// ==== verilog/mmrd_mem_if.sv ====
// Memory port bundle between the decoder and its memory arrays.
`timescale 1ns/100ps
`default_nettype none
interface mmrd_mem_if #(parameter int AW = 11, parameter int DW = 32);
  logic          en;
  logic          we;
  logic [DW/8-1:0] be;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport ctrl (output en, we, be, addr, wdata, input rdata);
  modport mem  (input en, we, be, addr, wdata, output rdata);
endinterface
`default_nettype wire

// ==== verilog/mmrd_sram.sv ====
// SRAM array of 2k 32-bit words with byte lanes and registered read data.
`timescale 1ns/100ps
`default_nettype none
module mmrd_sram
  import mmrd_pkg::*;
(
  input wire logic clk_sys,  // System clock
  mmrd_mem_if.mem  port      // Access port
);

  genvar g;
  // One byte-wide array per lane so partial writes leave other lanes alone
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      logic [7:0] lane [SRAM_WORDS];
      logic [7:0] rd_q;
      always_ff @(posedge clk_sys) begin
        if (port.en && port.we && port.be[g]) begin
          lane[port.addr] <= port.wdata[g*8 +: 8];
        end
        if (port.en && !port.we) begin
          rd_q <= lane[port.addr];
        end
      end
      assign port.rdata[g*8 +: 8] = rd_q;
    end
  endgenerate

endmodule // mmrd_sram
`default_nettype wire

// ==== verilog/mmrd_nvarray.sv ====
// Nonvolatile array of 64k halfwords covering both blocks, registered read.
`timescale 1ns/100ps
`default_nettype none
module mmrd_nvarray
  import mmrd_pkg::*;
(
  input wire logic clk_sys,  // System clock
  mmrd_mem_if.mem  port      // Access port
);

  genvar g;
  // Two byte lanes of one 16-bit wide array
  generate
    for (g = 0; g < 2; g++) begin : g_lane
      logic [7:0] lane [NV_HW_DEPTH];
      logic [7:0] rd_q;
      always_ff @(posedge clk_sys) begin
        if (port.en && port.we && port.be[g]) begin
          lane[port.addr] <= port.wdata[g*8 +: 8];
        end
        if (port.en && !port.we) begin
          rd_q <= lane[port.addr];
        end
      end
      assign port.rdata[g*8 +: 8] = rd_q;
    end
  endgenerate

endmodule // mmrd_nvarray
`default_nettype wire

// ==== verilog/mmrd_decoder.sv ====
// Memory map decoder with address zero remap, SRAM and 16-bit nonvolatile array.
`timescale 1ns/100ps
`default_nettype none
module mmrd_decoder
  import mmrd_pkg::*;
(
  input  wire logic            clk_sys,    // System clock
  input  wire logic            reset_n,    // Synchronous reset, active low
  input  wire logic            busReq,     // Core access request, held until ready
  input  wire logic [31:0]     busAddr,    // Byte address
  input  wire logic            busWrite,   // 1 write, 0 read
  input  wire mmrd_size_t      busSize,    // Byte, halfword or word
  input  wire logic            busFetch,   // Instruction fetch marker
  input  wire logic [31:0]     busWdata,   // Write data in address lanes
  output logic [31:0]          busRdata,   // Read data, registered
  output logic                 busReady,   // Access complete, one cycle
  output logic                 remapSram,  // SRAM currently at address zero
  output logic [NV_PAGE_W-1:0] nvPage,     // Page of the last array access
  input  wire logic            progWr,     // Array load strobe
  input  wire logic [NV_AW-1:0] progAddr,  // Array load halfword index
  input  wire logic [15:0]     progData,   // Array load data
  output logic                 progReady   // Array load accepted this cycle
);

  mmrd_mem_if #(.AW(SRAM_AW), .DW(32)) sramIf ();
  mmrd_mem_if #(.AW(NV_AW),   .DW(16)) nvIf ();

  mmrd_state_t              state_q;
  mmrd_state_t              state_d;
  mmrd_region_t             region;
  mmrd_region_t             region_q;
  logic [31:0]              addr_q;
  logic [REMAP_W-1:0]       remap_q;
  logic [15:0]              lo_q;
  logic [31:0]              rdata_q;
  logic [NV_PAGE_W-1:0]     page_q;
  logic                     take;
  logic                     progTake;
  logic                     progBoot;
  logic [3:0]               lanes;
  logic                     isWord;

  mmrd_sram u_sram (
    .clk_sys (clk_sys),
    .port    (sramIf)
  );

  mmrd_nvarray u_nvarray (
    .clk_sys (clk_sys),
    .port    (nvIf)
  );

  // Map an address to its target; fetch and data share one decode
  function automatic mmrd_region_t decode_region(input logic [31:0] a, input logic sramAtZero);
    if (a[31:2] == REMAP_ADDR[31:2]) begin
      return RG_REMAP;
    end else if (a < MIRROR_BYTES) begin
      if (sramAtZero) begin
        return (a < SRAM_BYTES) ? RG_SRAM : RG_NONE;
      end
      return RG_NV;
    end else if (a >= SRAM_BASE && a < SRAM_BASE + SRAM_BYTES) begin
      return RG_SRAM;
    end else if (a >= NV_BLK1_BASE && a < NV_BLK1_BASE + NV_SPAN) begin
      return RG_NV;
    end
    return RG_NONE;
  endfunction

  // Request decode
  assign remapSram = ~remap_q[REMAP_SEL_BIT];
  assign region    = decode_region(busAddr, remapSram);
  assign lanes     = byte_lanes(busSize, busAddr[1:0]);
  assign isWord    = (busSize == SZ_WORD);
  assign progReady = (state_q == ST_IDLE);
  assign progTake  = progWr && progReady;
  assign progBoot  = (progAddr >= NV_BOOT_START);
  assign take      = (state_q == ST_IDLE) && busReq && !progWr;
  assign busReady  = (state_q == ST_DONE);
  assign busRdata  = rdata_q;
  assign nvPage    = page_q;

  // Next state of the access sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (take) begin
          if (region == RG_SRAM && !busWrite) begin
            state_d = ST_MEM;
          end else if (region == RG_NV && !busWrite) begin
            state_d = isWord ? ST_NV_HI : ST_MEM;
          end else begin
            state_d = ST_DONE;
          end
        end
      end
      ST_MEM:    state_d = ST_DONE;
      ST_NV_HI:  state_d = ST_NV_CAP;
      ST_NV_CAP: state_d = ST_DONE;
      ST_DONE:   state_d = ST_IDLE;
    endcase
  end

  // Sequencer state
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Latched request
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      addr_q   <= 32'h00000000;
      region_q <= RG_NONE;
    end else if (take) begin
      addr_q   <= busAddr;
      region_q <= region;
    end
  end

  // Remap control byte; reset puts the array at zero
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      remap_q <= REMAP_RST;
    end else if (take && region == RG_REMAP && busWrite && lanes[0]) begin
      remap_q <= busWdata[REMAP_W-1:0];
    end
  end

  // Page of the last array access
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      page_q <= 8'h00;
    end else if (take && region == RG_NV) begin
      page_q <= busAddr[PAGE_LSB +: NV_PAGE_W];
    end
  end

  // Memory port drive; array loads win the idle slot, core writes to the array are dropped
  always_comb begin
    sramIf.en    = 1'b0;
    sramIf.we    = 1'b0;
    sramIf.be    = 4'h0;
    sramIf.addr  = busAddr[SRAM_IDX_LSB +: SRAM_AW];
    sramIf.wdata = busWdata;
    nvIf.en      = 1'b0;
    nvIf.we      = 1'b0;
    nvIf.be      = 2'h0;
    nvIf.addr    = busAddr[NV_HW_LSB +: NV_AW];
    nvIf.wdata   = progData;
    if (progTake) begin
      nvIf.en   = !progBoot;
      nvIf.we   = 1'b1;
      nvIf.be   = 2'h3;
      nvIf.addr = progAddr;
    end else if (take && region == RG_SRAM) begin
      sramIf.en = 1'b1;
      sramIf.we = busWrite;
      sramIf.be = lanes;
    end else if (take && region == RG_NV && !busWrite) begin
      nvIf.en = 1'b1;
      if (isWord) begin
        nvIf.addr = {busAddr[NV_HW_LSB + 1 +: NV_AW - 1], 1'b0};
      end
    end else if (state_q == ST_NV_HI) begin
      nvIf.en   = 1'b1;
      nvIf.addr = {addr_q[NV_HW_LSB + 1 +: NV_AW - 1], 1'b1};
    end
  end

  // Low halfword of a split word fetch
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      lo_q <= 16'h0000;
    end else if (state_q == ST_NV_HI) begin
      lo_q <= nvIf.rdata;
    end
  end

  // Read data assembly in little-endian lanes
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rdata_q <= 32'h00000000;
    end else if (take) begin
      if (region == RG_REMAP && !busWrite) begin
        rdata_q <= {24'h000000, remap_q};
      end else begin
        rdata_q <= 32'h00000000;
      end
    end else if (state_q == ST_MEM) begin
      if (region_q == RG_SRAM) begin
        rdata_q <= sramIf.rdata;
      end else if (addr_q[1]) begin
        rdata_q <= {nvIf.rdata, 16'h0000};
      end else begin
        rdata_q <= {16'h0000, nvIf.rdata};
      end
    end else if (state_q == ST_NV_CAP) begin
      rdata_q <= {nvIf.rdata, lo_q};
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_nv_word_take;
    take && region == RG_NV && !busWrite && isWord;
  endsequence

  sequence s_split_walk;
    state_q == ST_NV_HI ##1 state_q == ST_NV_CAP ##1 busReady;
  endsequence

  sequence s_sram_read_take;
    take && region == RG_SRAM && !busWrite;
  endsequence

  chk_reset_flash_zero: assert property (
    $rose(reset_n) |-> !remapSram && decode_region(32'h00000000, remapSram) == RG_NV)
    else $error("array not at address zero after reset");

  chk_remap_to_sram: assert property (
    take && region == RG_REMAP && busWrite && lanes[0] && !busWdata[REMAP_SEL_BIT]
    |=> remapSram && busReady)
    else $error("clearing remap bit did not move SRAM to zero");

  chk_split_fetch_walk: assert property (
    s_nv_word_take |=> s_split_walk)
    else $error("word fetch from array not split into two halfwords");

  chk_split_hw_order: assert property (
    state_q == ST_NV_HI |-> nvIf.en && nvIf.addr[0] && $past(nvIf.addr[0]) == 1'b0)
    else $error("halfword order of split fetch wrong");

  chk_split_word_lanes: assert property (
    state_q == ST_NV_CAP |=> busRdata == {$past(nvIf.rdata), $past(lo_q)})
    else $error("split word not assembled little-endian");

  chk_sram_single_access: assert property (
    s_sram_read_take |-> sramIf.en ##1 !sramIf.en ##1 busReady)
    else $error("SRAM word not served in one access");

  chk_unmapped_zero: assert property (
    take && region == RG_NONE |-> !sramIf.en && !nvIf.en ##1 busReady && busRdata == 32'h00000000)
    else $error("unmapped access did not answer zero next cycle");

  chk_no_stall: assert property (
    take |-> ##[1:3] busReady)
    else $error("access took too long");

  chk_page_track: assert property (
    take && region == RG_NV |=> nvPage == $past(busAddr[PAGE_LSB +: NV_PAGE_W]))
    else $error("page index not tracked");

  chk_boot_protect: assert property (
    progTake && progBoot |-> !nvIf.en)
    else $error("boot page overwritten");

endmodule // mmrd_decoder
`default_nettype wire

// ==== verif/mmrd_core_model.sv ====
// Core-side bus master model that issues one decoder access at a time.
`timescale 1ns/100ps
`default_nettype none
module mmrd_core_model
  import mmrd_pkg::*;
(
  input  wire logic        clk_sys,   // System clock
  output logic             busReq,    // Request level
  output logic [31:0]      busAddr,   // Byte address
  output logic             busWrite,  // High for write
  output var mmrd_size_t   busSize,   // Access size
  output logic             busFetch,  // Fetch marker
  output logic [31:0]      busWdata,  // Write data in its lanes
  input  wire logic [31:0] busRdata,  // Read data
  input  wire logic        busReady   // Completion pulse
);
  // Bus idle at time zero
  initial begin
    busReq   = 1'b0;
    busAddr  = 32'h0;
    busWrite = 1'b0;
    busSize  = SZ_WORD;
    busFetch = 1'b0;
    busWdata = 32'h0;
  end

  // One access: raised after a falling edge, held until ready, then released.
  // Released address and data are inverted so stale values never pass.
  task automatic access(input logic wr, input logic [31:0] a, input mmrd_size_t sz,
                        input logic fe, input logic [31:0] wd,
                        output logic [31:0] rd, output int lat);
    lat = 0;
    @(negedge clk_sys);
    busReq   <= 1'b1;
    busAddr  <= a;
    busWrite <= wr;
    busSize  <= sz;
    busFetch <= fe;
    busWdata <= wd;
    do begin
      @(negedge clk_sys);
      lat++;
    end while (busReady !== 1'b1 && lat < 20);
    rd = busRdata;
    busReq   <= 1'b0;
    busAddr  <= ~a;
    busWdata <= ~wd;
  endtask
endmodule // mmrd_core_model
`default_nettype wire

// ==== verif/memory_map_remap_decoder_bench.sv ====
// Self-checking bench for the memory map remap decoder.
`timescale 1ns/100ps
`default_nettype none
module memory_map_remap_decoder_bench;
  import mmrd_pkg::*;
  logic                 clk_sys, reset_n, busReq, busWrite, busFetch, busReady;
  logic                 remapSram, progWr, progReady;
  logic [31:0]          busAddr, busWdata, busRdata;
  mmrd_size_t           busSize;
  logic [NV_PAGE_W-1:0] nvPage;
  logic [NV_AW-1:0]     progAddr;
  logic [15:0]          progData;
  int                   errTotal, nChecks;

  mmrd_decoder dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .busReq(busReq),
    .busAddr(busAddr), .busWrite(busWrite), .busSize(busSize), .busFetch(busFetch),
    .busWdata(busWdata), .busRdata(busRdata), .busReady(busReady),
    .remapSram(remapSram), .nvPage(nvPage), .progWr(progWr), .progAddr(progAddr),
    .progData(progData), .progReady(progReady));
  mmrd_core_model core_u (.clk_sys(clk_sys), .busReq(busReq), .busAddr(busAddr),
    .busWrite(busWrite), .busSize(busSize), .busFetch(busFetch),
    .busWdata(busWdata), .busRdata(busRdata), .busReady(busReady));

  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Verdict and end of run
  task automatic finishTest();
    if (errTotal == 0 && nChecks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Array load pattern by halfword index
  function automatic logic [15:0] hw(input logic [15:0] idx);
    return idx ^ 16'h5A3C;
  endfunction

  // One bus access; a hang ends the run
  task automatic acc(input logic wr, input logic [31:0] a, input mmrd_size_t sz,
                     input logic fe, input logic [31:0] wd,
                     output logic [31:0] rd, output int lat);
    core_u.access(wr, a, sz, fe, wd, rd, lat);
    if (lat >= 20) begin
      errTotal++;
      finishTest();
    end
  endtask

  // Read and check data and latency
  task automatic rdChk(input string what, input logic [31:0] a, input mmrd_size_t sz,
                       input logic fe, input logic [31:0] exp, input int expLat);
    logic [31:0] rd;
    int          lat;
    acc(1'b0, a, sz, fe, 32'h0, rd, lat);
    chk(what, rd, exp);
    chk({what, " lat"}, lat, expLat);
  endtask

  // Write and check latency and zero read data
  task automatic wrChk(input string what, input logic [31:0] a, input mmrd_size_t sz,
                       input logic [31:0] wd, input int expLat);
    logic [31:0] rd;
    int          lat;
    acc(1'b1, a, sz, 1'b0, wd, rd, lat);
    chk(what, rd, 32'h0);
    chk({what, " lat"}, lat, expLat);
  endtask

  // Load one halfword through the load port
  task automatic loadHw(input logic [15:0] idx);
    @(negedge clk_sys);
    chk("progReady", progReady, 1'b1);
    progWr   <= 1'b1;
    progAddr <= idx;
    progData <= hw(idx);
    @(negedge clk_sys);
    progWr   <= 1'b0;
  endtask

  // Hold reset for five cycles
  task automatic doReset();
    @(negedge clk_sys);
    reset_n <= 1'b0;
    repeat (5) @(negedge clk_sys);
    reset_n <= 1'b1;
    @(negedge clk_sys);
  endtask

  // Reset values and the remap byte
  task automatic tReset();
    chk("ready", busReady, 1'b0);
    chk("rdata", busRdata, 32'h0);
    chk("remapSram", remapSram, 1'b0);
    chk("nvPage", nvPage, 8'h00);
    rdChk("remap rst", 32'hFFFF0220, SZ_WORD, 1'b0, 32'h1, 1);
  endtask

  // Halfword split, block windows, lanes and pages of the array
  task automatic tArray();
    loadHw(16'h0002);
    loadHw(16'h0003);
    loadHw(16'h8000);
    loadHw(16'h8001);
    loadHw(16'hFBFF);
    loadHw(16'hFC00);
    rdChk("blk1 word", 32'h80004, SZ_WORD, 1'b0, {hw(3), hw(2)}, 3);
    chk("page blk1", nvPage, 8'h00);
    rdChk("blk0 word", 32'h90000, SZ_WORD, 1'b1, {hw(16'h8001), hw(16'h8000)}, 3);
    chk("page blk0", nvPage, 8'h80);
    rdChk("blk0 half", 32'h90002, SZ_HALF, 1'b0, {hw(16'h8001), 16'h0}, 2);
    rdChk("blk0 byte", 32'h90001, SZ_BYTE, 1'b0, {16'h0, hw(16'h8000)}, 2);
    rdChk("blk0 top", 32'h9F7FE, SZ_HALF, 1'b0, {hw(16'hFBFF), 16'h0}, 2);
    chk("page top", nvPage, 8'hFB);
    rdChk("mirror fetch", 32'h4, SZ_WORD, 1'b1, {hw(3), hw(2)}, 3);
    rdChk("mirror data", 32'h4, SZ_WORD, 1'b0, {hw(3), hw(2)}, 3);
    wrChk("nv write", 32'h80004, SZ_WORD, 32'hDEADBEEF, 1);
    rdChk("nv kept", 32'h80004, SZ_WORD, 1'b0, {hw(3), hw(2)}, 3);
  endtask

  // SRAM byte lanes, single-access words, last word
  task automatic tSram();
    wrChk("sr w0", 32'h40000, SZ_WORD, 32'h11223344, 1);
    wrChk("sr w1", 32'h40004, SZ_WORD, 32'h0, 1);
    wrChk("sr b5", 32'h40005, SZ_BYTE, 32'h0000AB00, 1);
    wrChk("sr h6", 32'h40006, SZ_HALF, 32'hCDEF0000, 1);
    rdChk("sr lanes", 32'h40004, SZ_WORD, 1'b0, 32'hCDEFAB00, 2);
    wrChk("sr top", 32'h41FFC, SZ_WORD, 32'h13579BDF, 1);
    rdChk("sr top", 32'h41FFC, SZ_WORD, 1'b0, 32'h13579BDF, 2);
  endtask

  // SRAM at zero, then back to the array on a mid-run reset
  task automatic tRemap();
    wrChk("remap clr", 32'hFFFF0220, SZ_BYTE, 32'h0, 1);
    chk("remapSram on", remapSram, 1'b1);
    rdChk("zero sram", 32'h0, SZ_WORD, 1'b1, 32'h11223344, 2);
    rdChk("mirror gap", 32'h2000, SZ_WORD, 1'b0, 32'h0, 1);
    rdChk("remap rd", 32'hFFFF0220, SZ_WORD, 1'b0, 32'h0, 1);
    doReset();
    chk("remapSram rst", remapSram, 1'b0);
    chk("rdata rst", busRdata, 32'h0);
    rdChk("zero nv", 32'h4, SZ_WORD, 1'b1, {hw(3), hw(2)}, 3);
  endtask

  // Holes in the map
  task automatic tHoles();
    wrChk("hole wr", 32'h50000, SZ_WORD, 32'hFFFFFFFF, 1);
    rdChk("hole rd", 32'h50000, SZ_WORD, 1'b0, 32'h0, 1);
    rdChk("past sram", 32'h42000, SZ_WORD, 1'b0, 32'h0, 1);
    rdChk("past nv", 32'hA0000, SZ_WORD, 1'b0, 32'h0, 1);
  endtask

  // Main sequence
  initial begin
    errTotal = 0;
    nChecks  = 0;
    reset_n  = 1'b0;
    progWr   = 1'b0;
    progAddr = '0;
    progData = 16'h0;
    repeat (5) @(negedge clk_sys);
    reset_n <= 1'b1;
    @(negedge clk_sys);
    tReset();
    tArray();
    tSram();
    tRemap();
    tHoles();
    finishTest();
  end
endmodule // memory_map_remap_decoder_bench
`default_nettype wire
